// >>> rtl/fzc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fzc_regs.svh"
// Operation
// - zone result goes to three consecutive bits
// - below both limits sets first bit
// - within limits sets bit at plus one
// - above limits sets bit at plus two
// - zone bits hold while disabled
// - lower limit above upper clears all bits
// - operands are single precision floats only
// - each operand is two 16-bit registers
// - add writes first plus second
// - subtract writes first minus second
// - multiply writes first times second
// - divide writes first over second
// - root of non-negative source only
// - destination may alias a source pair
// - execute only while enable is active
// - power raises first to the integer part of second
module fzc_top
   import fzc_pkg::*;
#(
   parameter int AW = 16 // operand and bit address width
)
(
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic instr_valid, // one-cycle issue strobe
   input wire logic exec_en, // input condition of the rung
   input wire logic [2:0] instr_op, // instruction code
   input wire logic [15:0] src1_lo, // first source, low register
   input wire logic [15:0] src1_hi, // first source, high register
   input wire logic [15:0] src2_lo, // second source, low register
   input wire logic [15:0] src2_hi, // second source, high register
   input wire logic [15:0] src3_lo, // tested value, low register
   input wire logic [15:0] src3_hi, // tested value, high register
   input wire logic [AW-1:0] dest_addr, // destination base address
   output logic busy, // arithmetic in progress
   output logic res_wr_en, // one-cycle result write
   output logic [AW-1:0] res_addr, // low register address
   output logic [15:0] res_lo, // data for res_addr
   output logic [15:0] res_hi, // data for res_addr + 1
   output logic bit_wr_en, // one-cycle zone bit write
   output logic [AW-1:0] bit_addr, // first of three bit addresses
   output logic [2:0] bit_vals, // bits for addr, +1, +2
   output logic op_err // one-cycle operation error
);

   // order key: sign-magnitude to unsigned, both zeros equal
   function automatic logic [31:0] ord_key(input logic [31:0] x);
      if (x[30:0] == 31'h00000000)
         ord_key = `FZC_ZERO_KEY;
      else if (x[`FZC_SIGN_BIT])
         ord_key = ~x;
      else
         ord_key = x | `FZC_ZERO_KEY;
   endfunction

   function automatic logic f_lt(input logic [31:0] x,
      input logic [31:0] y);
      f_lt = ord_key(x) < ord_key(y);
   endfunction

   // zone bits {plus two, plus one, first}
   function automatic logic [2:0] zone_bits(input logic [31:0] lo,
      input logic [31:0] hi, input logic [31:0] s);
      if (f_lt(hi, lo))
         zone_bits = 3'b000;
      else if (f_lt(s, lo))
         zone_bits = 3'b001;
      else if (f_lt(hi, s))
         zone_bits = 3'b100;
      else
         zone_bits = 3'b010;
   endfunction

   // integer part of the exponent; fraction dropped, huge is refused
   function automatic logic [31:0] pow_int(input logic [31:0] y);
      logic [7:0] e;
      logic [31:0] m, sh;
      e = y[`FZC_EXP_MSB:`FZC_EXP_LSB];
      m = {8'h00, 1'b1, y[`FZC_FRAC_MSB:0]};
      sh = 32'h00000000;
      if (e < `FZC_POW_EMIN)
         pow_int = 32'h00000000;
      else if (e > `FZC_POW_EMAX)
         pow_int = 32'h80000000;
      else
      begin
         if (e >= `FZC_POW_EPT)
            sh = m << (e - `FZC_POW_EPT);
         else
            sh = m >> (`FZC_POW_EPT - e);
         pow_int = {1'b0, sh[30:0]};
      end
   endfunction

   fzc_state_e state_reg;
   fzc_op_e op_e;
   logic [31:0] s1, s2, s3, pw;
   logic accept;
   logic busy_reg, res_wr_en_reg, bit_wr_en_reg, op_err_reg;
   logic [AW-1:0] res_addr_reg, bit_addr_reg;
   logic [31:0] res_reg;
   logic [2:0] bit_vals_reg;
   logic core_start_reg;
   logic [1:0] core_op_reg;
   logic [31:0] core_a_reg, core_b_reg;
   logic core_done, core_err;
   logic [31:0] core_res;
   logic [31:0] acc_reg, base_reg;
   logic [30:0] npow_reg;
   logic neg_reg;

   // operands assembled high:low as single precision words
   assign s1 = {src1_hi, src1_lo};
   assign s2 = {src2_hi, src2_lo};
   assign s3 = {src3_hi, src3_lo};
   assign op_e = fzc_op_e'(instr_op);
   assign pw = pow_int(s2);
   // a request with the condition low does nothing at all
   assign accept = instr_valid & exec_en & ~busy_reg;

   assign busy = busy_reg;
   assign res_wr_en = res_wr_en_reg;
   assign res_addr = res_addr_reg;
   assign res_lo = res_reg[15:0];
   assign res_hi = res_reg[31:16];
   assign bit_wr_en = bit_wr_en_reg;
   assign bit_addr = bit_addr_reg;
   assign bit_vals = bit_vals_reg;
   assign op_err = op_err_reg;

   fzc_fp_core u_core (
      .clk(clk),
      .rst(rst),
      .start(core_start_reg),
      .op(core_op_reg),
      .a(core_a_reg),
      .b(core_b_reg),
      .done(core_done),
      .result(core_res),
      .err(core_err)
   );

   // sequencer; power runs square-and-multiply on the core
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= fzc_st_idle;
         busy_reg <= 1'b0;
         core_start_reg <= 1'b0;
         core_op_reg <= fzc_c_add;
         core_a_reg <= 32'h00000000;
         core_b_reg <= 32'h00000000;
         acc_reg <= 32'h00000000;
         base_reg <= 32'h00000000;
         npow_reg <= 31'h00000000;
         neg_reg <= 1'b0;
      end
      else
      begin
         core_start_reg <= 1'b0;
         case (state_reg)
            fzc_st_idle:
               if (accept)
               begin
                  // sources are latched here, so aliasing is safe
                  core_a_reg <= s1;
                  core_b_reg <= s2;
                  case (op_e)
                     fzc_op_add, fzc_op_mul, fzc_op_div, fzc_op_sqrt:
                     begin
                        core_start_reg <= 1'b1;
                        busy_reg <= 1'b1;
                        state_reg <= fzc_st_wait;
                        if (op_e == fzc_op_add)
                           core_op_reg <= fzc_c_add;
                        else if (op_e == fzc_op_mul)
                           core_op_reg <= fzc_c_mul;
                        else if (op_e == fzc_op_div)
                           core_op_reg <= fzc_c_div;
                        else
                           core_op_reg <= fzc_c_sqrt;
                     end
                     fzc_op_sub:
                     begin
                        core_start_reg <= 1'b1;
                        busy_reg <= 1'b1;
                        state_reg <= fzc_st_wait;
                        core_op_reg <= fzc_c_add;
                        core_b_reg <= {~s2[31], s2[30:0]};
                     end
                     fzc_op_pow:
                        if (!pw[31])
                        begin
                           acc_reg <= `FZC_ONE;
                           base_reg <= s1;
                           npow_reg <= pw[30:0];
                           neg_reg <= s2[`FZC_SIGN_BIT];
                           busy_reg <= 1'b1;
                           state_reg <= fzc_st_pstep;
                        end
                     default:
                        state_reg <= fzc_st_idle;
                  endcase
               end
            fzc_st_wait:
               if (core_done)
               begin
                  busy_reg <= 1'b0;
                  state_reg <= fzc_st_idle;
               end
            fzc_st_pstep:
               if (npow_reg == 31'h00000000)
               begin
                  if (neg_reg)
                  begin
                     // negative exponent: one reciprocal at the end
                     core_start_reg <= 1'b1;
                     core_op_reg <= fzc_c_div;
                     core_a_reg <= `FZC_ONE;
                     core_b_reg <= acc_reg;
                     state_reg <= fzc_st_wait;
                  end
                  else
                  begin
                     busy_reg <= 1'b0;
                     state_reg <= fzc_st_idle;
                  end
               end
               else
               begin
                  core_start_reg <= 1'b1;
                  core_op_reg <= fzc_c_mul;
                  core_a_reg <= npow_reg[0] ? acc_reg : base_reg;
                  core_b_reg <= base_reg;
                  state_reg <= npow_reg[0] ? fzc_st_pmula : fzc_st_psq;
               end
            fzc_st_pmula:
               if (core_done)
               begin
                  acc_reg <= core_res;
                  core_start_reg <= 1'b1;
                  core_a_reg <= base_reg;
                  core_b_reg <= base_reg;
                  state_reg <= fzc_st_psq;
               end
            fzc_st_psq:
               if (core_done)
               begin
                  base_reg <= core_res;
                  npow_reg <= {1'b0, npow_reg[30:1]};
                  state_reg <= fzc_st_pstep;
               end
            default:
               state_reg <= fzc_st_idle;
         endcase
      end
   end

   // writes toward data registers and bit relays
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         res_wr_en_reg <= 1'b0;
         res_addr_reg <= '0;
         res_reg <= 32'h00000000;
         bit_wr_en_reg <= 1'b0;
         bit_addr_reg <= '0;
         bit_vals_reg <= 3'b000;
         op_err_reg <= 1'b0;
      end
      else
      begin
         res_wr_en_reg <= 1'b0;
         bit_wr_en_reg <= 1'b0;
         op_err_reg <= 1'b0;
         if (accept && op_e == fzc_op_zone)
         begin
            // bits change only on an enabled scan, else they hold
            bit_wr_en_reg <= 1'b1;
            bit_addr_reg <= dest_addr;
            bit_vals_reg <= zone_bits(s1, s2, s3);
         end
         if (accept && op_e != fzc_op_zone)
            res_addr_reg <= dest_addr;
         if (accept && op_e == fzc_op_pow && pw[31])
            op_err_reg <= 1'b1;
         if (state_reg == fzc_st_wait && core_done)
         begin
            if (core_err)
               op_err_reg <= 1'b1;
            else
            begin
               res_wr_en_reg <= 1'b1;
               res_reg <= core_res;
            end
         end
         if (state_reg == fzc_st_pstep && npow_reg == 31'h00000000
            && !neg_reg)
         begin
            res_wr_en_reg <= 1'b1;
            res_reg <= acc_reg;
         end
      end
   end

endmodule
`default_nettype wire

// >>> rtl/fzc_regs.svh
`ifndef FZC_REGS_SVH
`define FZC_REGS_SVH

// single-precision field layout
`define FZC_SIGN_BIT 31
`define FZC_EXP_MSB 30
`define FZC_EXP_LSB 23
`define FZC_FRAC_MSB 22

// exponent bias and fixed encodings
`define FZC_BIAS 10'sh07f
`define FZC_ONE 32'h3f800000
`define FZC_ZERO_KEY 32'h80000000

// integer power exponent window (biased exponents 127 .. 157)
`define FZC_POW_EMIN 8'h7f
`define FZC_POW_EMAX 8'h9d
`define FZC_POW_EPT 8'h96

// iteration counts of the serial divider and root unit
`define FZC_DIV_STEPS 5'h19
`define FZC_SQRT_STEPS 5'h18

`endif

// >>> rtl/fzc_pkg.sv
package fzc_pkg;

   // instruction codes on the issue port
   typedef enum logic [2:0] {
      fzc_op_zone = 3'b000,
      fzc_op_add = 3'b001,
      fzc_op_sub = 3'b010,
      fzc_op_mul = 3'b011,
      fzc_op_div = 3'b100,
      fzc_op_sqrt = 3'b101,
      fzc_op_pow = 3'b110
   } fzc_op_e;

   // operations of the arithmetic core
   typedef enum logic [1:0] {
      fzc_c_add = 2'b00,
      fzc_c_mul = 2'b01,
      fzc_c_div = 2'b10,
      fzc_c_sqrt = 2'b11
   } fzc_core_op_e;

   // sequencer states
   typedef enum logic [2:0] {
      fzc_st_idle = 3'b000,
      fzc_st_wait = 3'b001,
      fzc_st_pstep = 3'b010,
      fzc_st_pmula = 3'b011,
      fzc_st_psq = 3'b100
   } fzc_state_e;

   // core states
   typedef enum logic {
      fzc_cs_idle = 1'b0,
      fzc_cs_iter = 1'b1
   } fzc_core_state_e;

endpackage

// >>> rtl/fzc_fp_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "fzc_regs.svh"
module fzc_fp_core
   import fzc_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic start, // one-cycle start
   input wire logic [1:0] op, // core operation
   input wire logic [31:0] a, // first operand
   input wire logic [31:0] b, // second operand
   output logic done, // one-cycle result pulse
   output logic [31:0] result, // result word
   output logic err // zero divisor or negative root
);

   // denormals read as zero; no rounding, results truncate
   function automatic logic [23:0] mant_of(input logic [31:0] x);
      if (x[`FZC_EXP_MSB:`FZC_EXP_LSB] == 8'h00)
         mant_of = 24'h000000;
      else
         mant_of = {1'b1, x[`FZC_FRAC_MSB:0]};
   endfunction

   // saturate to infinity, flush underflow to zero
   function automatic logic [31:0] pack(input logic s,
      input logic signed [9:0] e, input logic [22:0] f);
      if (e <= 10'sh000)
         pack = {s, 31'h00000000};
      else if (e >= 10'sh0ff)
         pack = {s, 8'hff, 23'h000000};
      else
         pack = {s, e[7:0], f};
   endfunction

   fzc_core_state_e st_reg;
   fzc_core_op_e opr_reg;
   logic [4:0] cnt_reg;
   logic [27:0] rem_reg;
   logic [24:0] q_reg;
   logic [47:0] rad_reg;
   logic [23:0] dvs_reg;
   logic sgn_reg;
   logic signed [9:0] ex_reg;
   logic sa, sb;
   logic [7:0] ea, eb, ebig, esml, d;
   logic [23:0] ma, mb, mbig, msml;
   logic swap;
   logic [26:0] sml;
   logic [27:0] sum, nrm, t, trial, dsub;
   logic [4:0] lz;
   logic signed [9:0] ae, me, se;
   logic [47:0] prod;
   logic [31:0] add_res, mul_res;
   logic div_ge, sq_ge;

   assign sa = a[`FZC_SIGN_BIT];
   assign sb = b[`FZC_SIGN_BIT];
   assign ea = a[`FZC_EXP_MSB:`FZC_EXP_LSB];
   assign eb = b[`FZC_EXP_MSB:`FZC_EXP_LSB];
   assign ma = mant_of(a);
   assign mb = mant_of(b);

   // single-cycle add: align smaller magnitude, then renormalise
   always_comb
   begin
      swap = {eb, mb} > {ea, ma};
      ebig = swap ? eb : ea;
      esml = swap ? ea : eb;
      mbig = swap ? mb : ma;
      msml = swap ? ma : mb;
      d = ebig - esml;
      sml = (d > 8'h1a) ? 27'h0000000 : ({msml, 3'b000} >> d);
      if (sa == sb)
         sum = {1'b0, mbig, 3'b000} + {1'b0, sml};
      else
         sum = {1'b0, mbig, 3'b000} - {1'b0, sml};
      lz = 5'h00;
      for (int i = 0; i < 28; i++)
         if (sum[i])
            lz = 5'(27 - i);
      nrm = sum << lz;
      ae = $signed({2'b00, ebig}) + 10'sh001 - $signed({5'h00, lz});
      if (sum == 28'h0000000)
         add_res = 32'h00000000;
      else
         add_res = pack(swap ? sb : sa, ae, nrm[26:4]);
   end

   // single-cycle multiply on full mantissas
   always_comb
   begin
      prod = ma * mb;
      me = $signed({2'b00, ea}) + $signed({2'b00, eb}) - `FZC_BIAS
         + $signed({9'h000, prod[47]});
      if (ma == 24'h000000 || mb == 24'h000000)
         mul_res = {sa ^ sb, 31'h00000000};
      else if (prod[47])
         mul_res = pack(sa ^ sb, me, prod[46:24]);
      else
         mul_res = pack(sa ^ sb, me, prod[45:23]);
   end

   // one restoring step of the divider or the root unit
   always_comb
   begin
      t = {rem_reg[25:0], rad_reg[47:46]};
      trial = {2'b00, q_reg[23:0], 2'b01};
      dsub = rem_reg - {4'h0, dvs_reg};
      div_ge = rem_reg >= {4'h0, dvs_reg};
      sq_ge = t >= trial;
      se = ($signed({2'b00, ea}) - `FZC_BIAS) >>> 1;
   end

   // control and iteration registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= fzc_cs_idle;
         opr_reg <= fzc_c_add;
         done <= 1'b0;
         err <= 1'b0;
         result <= 32'h00000000;
         cnt_reg <= 5'h00;
         rem_reg <= 28'h0000000;
         q_reg <= 25'h0000000;
         rad_reg <= 48'h000000000000;
         dvs_reg <= 24'h000000;
         sgn_reg <= 1'b0;
         ex_reg <= 10'sh000;
      end
      else
      begin
         done <= 1'b0;
         err <= 1'b0;
         case (st_reg)
            fzc_cs_idle:
               if (start)
               begin
                  opr_reg <= fzc_core_op_e'(op);
                  case (fzc_core_op_e'(op))
                     fzc_c_add:
                     begin
                        done <= 1'b1;
                        result <= add_res;
                     end
                     fzc_c_mul:
                     begin
                        done <= 1'b1;
                        result <= mul_res;
                     end
                     fzc_c_div:
                     begin
                        // zero divisor leaves the result untouched
                        if (mb == 24'h000000)
                        begin
                           done <= 1'b1;
                           err <= 1'b1;
                        end
                        else if (ma == 24'h000000)
                        begin
                           done <= 1'b1;
                           result <= {sa ^ sb, 31'h00000000};
                        end
                        else
                        begin
                           rem_reg <= {4'h0, ma};
                           q_reg <= 25'h0000000;
                           dvs_reg <= mb;
                           sgn_reg <= sa ^ sb;
                           ex_reg <= $signed({2'b00, ea})
                              - $signed({2'b00, eb}) + `FZC_BIAS;
                           cnt_reg <= `FZC_DIV_STEPS;
                           st_reg <= fzc_cs_iter;
                        end
                     end
                     default:
                     begin
                        if (ma == 24'h000000)
                        begin
                           done <= 1'b1;
                           result <= {sa, 31'h00000000};
                        end
                        else if (sa)
                        begin
                           done <= 1'b1;
                           err <= 1'b1;
                        end
                        else
                        begin
                           // even unbiased exponent keeps one bit less
                           rad_reg <= ea[0] ? {1'b0, ma, 23'h000000}
                              : {ma, 24'h000000};
                           rem_reg <= 28'h0000000;
                           q_reg <= 25'h0000000;
                           ex_reg <= se + `FZC_BIAS;
                           cnt_reg <= `FZC_SQRT_STEPS;
                           st_reg <= fzc_cs_iter;
                        end
                     end
                  endcase
               end
            fzc_cs_iter:
               if (cnt_reg == 5'h00)
               begin
                  done <= 1'b1;
                  st_reg <= fzc_cs_idle;
                  if (opr_reg == fzc_c_sqrt)
                     result <= pack(1'b0, ex_reg, q_reg[22:0]);
                  else if (q_reg[24])
                     result <= pack(sgn_reg, ex_reg, q_reg[23:1]);
                  else
                     result <= pack(sgn_reg, ex_reg - 10'sh001,
                        q_reg[22:0]);
               end
               else
               begin
                  cnt_reg <= cnt_reg - 5'h01;
                  q_reg <= {q_reg[23:0],
                     (opr_reg == fzc_c_sqrt) ? sq_ge : div_ge};
                  if (opr_reg == fzc_c_sqrt)
                  begin
                     rem_reg <= sq_ge ? t - trial : t;
                     rad_reg <= {rad_reg[45:0], 2'b00};
                  end
                  else
                     rem_reg <= div_ge ? {dsub[26:0], 1'b0}
                        : {rem_reg[26:0], 1'b0};
               end
            default:
               st_reg <= fzc_cs_idle;
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> tb/fzc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module fzc_top_chk
#(
   parameter int AW = 16 // address width
)
(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic instr_valid, // strobe
   input wire logic exec_en, // rung condition
   input wire logic [2:0] instr_op, // code
   input wire logic [15:0] src1_lo, // s1 low
   input wire logic [15:0] src1_hi, // s1 high
   input wire logic [15:0] src2_lo, // s2 low
   input wire logic [15:0] src2_hi, // s2 high
   input wire logic [15:0] src3_lo, // s low
   input wire logic [15:0] src3_hi, // s high
   input wire logic [AW-1:0] dest_addr, // destination
   input wire logic busy, // busy
   input wire logic res_wr_en, // result write
   input wire logic [AW-1:0] res_addr, // result address
   input wire logic [15:0] res_lo, // result low
   input wire logic [15:0] res_hi, // result high
   input wire logic bit_wr_en, // zone write
   input wire logic [AW-1:0] bit_addr, // zone address
   input wire logic [2:0] bit_vals, // zone bits
   input wire logic op_err // error pulse
);
   // a request counts only when enabled and idle
   wire acc = instr_valid && exec_en && !busy;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   a_zone_write: assert property (acc && instr_op == 3'h0 |=>
      bit_wr_en && bit_addr == $past(dest_addr)) else $error("zone write");
   a_zone_onehot: assert property (bit_wr_en |->
      $onehot0(bit_vals)) else $error("zone bits");
   a_zone_hold: assert property (!bit_wr_en |->
      $stable(bit_vals)) else $error("zone bits moved");
   a_no_enable: assert property (instr_valid && !exec_en && !busy |=>
      !bit_wr_en && !busy && !res_wr_en) else $error("ran disabled");
   // core start, core done and the write pulse are each one register deep
   a_arith_lat: assert property (acc && instr_op inside {3'h1, 3'h2, 3'h3}
      |=> busy ##1 busy ##1 ((res_wr_en || op_err) && !busy))
      else $error("arith lat");
   a_slow_lat: assert property (acc && instr_op inside {3'h4, 3'h5}
      |=> busy ##[1:28] (res_wr_en || op_err)) else $error("div lat");
   a_err_nowrite: assert property (op_err |->
      !res_wr_en && !busy) else $error("write on error");
   // the address is taken at accept, the data only with the write pulse
   a_res_hold: assert property (!res_wr_en |->
      $stable({res_hi, res_lo}) && ($stable(res_addr)
      || $past(acc && instr_op != 3'h0))) else $error("result moved");
   c_zone: cover property (acc && instr_op == 3'h0);
   c_pow: cover property (acc && instr_op == 3'h6);
   c_err: cover property (op_err);
endmodule
bind fzc_top fzc_top_chk #(.AW(AW)) chk_i (.clk, .rst, .instr_valid, .exec_en,
   .instr_op, .src1_lo, .src1_hi, .src2_lo, .src2_hi, .src3_lo, .src3_hi,
   .dest_addr, .busy, .res_wr_en, .res_addr, .res_lo, .res_hi, .bit_wr_en,
   .bit_addr, .bit_vals, .op_err);
`default_nettype wire

// >>> tb/fzc_issuer.sv
`timescale 1ns/1ns
`default_nettype none
module fzc_issuer
(
   input wire logic clk, // clock
   output logic instr_valid, // strobe
   output logic exec_en, // rung condition
   output logic [2:0] instr_op, // code
   output logic [31:0] s1, // first pair
   output logic [31:0] s2, // second pair
   output logic [31:0] s3, // tested pair
   output logic [15:0] dest_addr // destination
);
   initial
   begin
      instr_valid = 1'b0;
      {exec_en, instr_op, s1, s2, s3, dest_addr} = '0;
   end
   // one strobe per scan; bad operands only when a test asks
   task automatic issue(logic [2:0] op, logic [31:0] a, logic [31:0] b,
      logic [31:0] s, logic [15:0] d, logic en);
      @(negedge clk);
      {instr_op, s1, s2, s3, dest_addr} = {op, a, b, s, d};
      exec_en = en;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb/fzc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fzc_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic instr_valid, exec_en, busy, res_wr_en, bit_wr_en, op_err;
   logic w_res, w_err, w_bit;
   logic [2:0] instr_op, bit_vals;
   logic [31:0] s1, s2, s3;
   logic [15:0] dest_addr, res_addr, res_lo, res_hi, bit_addr, d;
   int fails = 0;
   int total_checks = 0;
   // last entry: negative exponent takes the reciprocal path
   logic [2:0] ops [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h6};
   logic [31:0] av [8] = '{32'h3f800000, 32'h40400000, 32'h40000000,
      32'h40c00000, 32'h41800000, 32'h40000000, 32'h3f800000, 32'h40000000};
   logic [31:0] bv [8] = '{32'h40000000, 32'h3f800000, 32'h40400000,
      32'h40000000, 32'h0, 32'h40400000, 32'h1, 32'hbf800000};
   logic [31:0] ev [8] = '{32'h40400000, 32'h40000000, 32'h40c00000,
      32'h40400000, 32'h40800000, 32'h41000000, 32'h3f800000, 32'h3f000000};
   always #4 clk = ~clk;
   fzc_issuer m (.clk(clk), .instr_valid(instr_valid), .exec_en(exec_en),
      .instr_op(instr_op), .s1(s1), .s2(s2), .s3(s3), .dest_addr(dest_addr));
   // pairs split low register low half
   fzc_top DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid),
      .exec_en(exec_en), .instr_op(instr_op), .src1_lo(s1[15:0]),
      .src1_hi(s1[31:16]), .src2_lo(s2[15:0]), .src2_hi(s2[31:16]),
      .src3_lo(s3[15:0]), .src3_hi(s3[31:16]), .dest_addr(dest_addr),
      .busy(busy), .res_wr_en(res_wr_en), .res_addr(res_addr),
      .res_lo(res_lo), .res_hi(res_hi), .bit_wr_en(bit_wr_en),
      .bit_addr(bit_addr), .bit_vals(bit_vals), .op_err(op_err));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   // positive floats order like unsigned words
   function automatic logic [2:0] zexp(logic [31:0] lo, hi, s);
      if (lo > hi)
         return 3'b000;
      if (s < lo)
         return 3'b001;
      return (s > hi) ? 3'b100 : 3'b010;
   endfunction
   function automatic logic [31:0] rpos();
      return ($urandom & 32'h3f7fffff) | 32'h40000000;
   endfunction
   // issue, then wait bounded for any answer pulse
   task automatic run(logic [2:0] op, logic [31:0] a, logic [31:0] b,
      logic [31:0] s, logic en);
      int n;
      d = 16'($urandom);
      m.issue(op, a, b, s, d, en);
      n = 0;
      while ({res_wr_en, op_err, bit_wr_en} !== 3'b100 &&
         {res_wr_en, op_err, bit_wr_en} !== 3'b010 &&
         {res_wr_en, op_err, bit_wr_en} !== 3'b001 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      {w_res, w_err, w_bit} = {res_wr_en, op_err, bit_wr_en};
      @(negedge clk);
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #(8 * 20000);
      fails++;
      summarize();
   end
   initial
   begin
      logic [31:0] lo, hi, s, prev;
      void'($urandom(32'h9970));
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         run(ops[i], av[i], bv[i], rpos(), 1'b1);
         chk("res_we", 1, w_res);
         chk("result", ev[i], {res_hi, res_lo});
         chk("res_addr", {16'h0, d}, {16'h0, res_addr});
      end
      // scan twice with destination fed back as source
      run(3'h1, 32'h41000000, 32'h3f800000, 32'h0, 1'b1);
      run(3'h1, {res_hi, res_lo}, 32'h3f800000, 32'h0, 1'b1);
      chk("alias", 32'h41200000, {res_hi, res_lo});
      $display("test arith done");
      prev = {res_hi, res_lo};
      run(3'h4, 32'h3f800000, 32'h0, 32'h0, 1'b1);
      chk("div_err", 1, w_err);
      run(3'h5, 32'hc0800000, 32'h0, 32'h0, 1'b1);
      chk("sqrt_err", 1, w_err);
      chk("kept", prev, {res_hi, res_lo});
      $display("test errors done");
      for (int i = 0; i < 30; i++)
      begin
         lo = rpos();
         hi = rpos();
         s = (i % 3 == 0) ? lo : (i % 3 == 1) ? hi : rpos();
         run(3'h0, lo, hi, s, 1'b1);
         chk("zone", {29'h0, zexp(lo, hi, s)}, {29'h0, bit_vals});
         chk("bit_addr", {16'h0, d}, {16'h0, bit_addr});
      end
      run(3'h0, 32'h40400000, 32'h40800000, 32'h40000000, 1'b1);
      chk("below", 1, {29'h0, bit_vals});
      run(3'h0, 32'h40400000, 32'h40800000, 32'h40400000, 1'b0);
      chk("no_write", 0, w_bit);
      chk("held", 1, {29'h0, bit_vals});
      $display("test zone done");
      summarize();
   end
endmodule
`default_nettype wire
